// [lacls_regs.svh]
// register offsets, field positions and reset values of the light alarm classifier
`ifndef LACLS_REGS_SVH
`define LACLS_REGS_SVH
`define LACLS_OFS_SEL_ONE 4'h0
`define LACLS_OFS_SEL_TWO 4'h1
`define LACLS_OFS_THERM 4'h2
`define LACLS_OFS_STATUS 4'h3
`define LACLS_OFS_MASK 4'h4
`define LACLS_OFS_DISP 4'h5
`define LACLS_SEL_RESET 16'h0000
`define LACLS_ONE_USED 16'hFC77
`define LACLS_TWO_USED 16'h3FFC
`define LACLS_THERM_BIT 11
`define LACLS_ST_MINOR 0
`define LACLS_ST_TRIP 1
`define LACLS_LED_DIV 26'h2FAF080
`endif

// [lacls_pkg.sv]
// types shared by the light alarm classifier files
package lacls_pkg;
  typedef logic [15:0] lacls_word_t;
  typedef logic [3:0] lacls_nib_t;
  typedef logic [7:0] lacls_char_t;
endpackage

// [lacls_hex_digit.sv]
// converts one 4-bit group into an ascii hexadecimal character
`timescale 1ns/10ps
module lacls_hex_digit
  import lacls_pkg::*;
(
  input wire lacls_nib_t nib_i,
  output lacls_char_t chr_o
);
  // lower-case a to f above nine
  always_comb begin
    if (nib_i < 4'hA) begin
      chr_o = 8'h30 + {4'h0, nib_i};
    end else begin
      chr_o = 8'h57 + {4'h0, nib_i};
    end
  end
endmodule

// [lacls_blink.sv]
// divider that toggles the keypad led blink phase
`timescale 1ns/10ps
`include "lacls_regs.svh"
module lacls_blink #(
  parameter logic [25:0] HALF = `LACLS_LED_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic phase_o
);
  logic [25:0] cnt;
  logic [25:0] next_cnt;
  logic next_phase;
  always_comb begin
    next_cnt = cnt + 26'h1;
    next_phase = phase_o;
    if (cnt >= HALF - 26'h1) begin
      next_cnt = 26'h0;
      next_phase = ~phase_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 26'h0;
      phase_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase_o <= next_phase;
    end
  end
endmodule

// [lacls_top.sv]
// light alarm classifier: masks, classification, display and wishbone slave
`timescale 1ns/10ps
`include "lacls_regs.svh"
module lacls_top
  import lacls_pkg::*;
#(
  parameter logic [25:0] BLINK_HALF = `LACLS_LED_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] fault_one_i,
  input wire logic [15:0] fault_two_i,
  output logic trip_o,
  output logic minor_alarm_output_o,
  output logic minor_ind_o,
  output logic keypad_led_o,
  output logic [7:0] disp_one_d3_o,
  output logic [7:0] disp_one_d2_o,
  output logic [7:0] disp_one_d1_o,
  output logic [7:0] disp_one_d0_o,
  output logic [7:0] disp_two_d3_o,
  output logic [7:0] disp_two_d2_o,
  output logic [7:0] disp_two_d1_o,
  output logic [7:0] disp_two_d0_o,
  output logic irq_o
);
  // ==========================================================
  // input synchronisers
  logic [15:0] f1_s1;
  logic [15:0] f1_s2;
  logic [15:0] f2_s1;
  logic [15:0] f2_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f1_s1 <= 16'h0000;
      f1_s2 <= 16'h0000;
      f2_s1 <= 16'h0000;
      f2_s2 <= 16'h0000;
    end else begin
      f1_s1 <= fault_one_i;
      f1_s2 <= f1_s1;
      f2_s1 <= fault_two_i;
      f2_s2 <= f2_s1;
    end
  end

  // ==========================================================
  // registers
  lacls_word_t minor_alarm_select_one;
  lacls_word_t minor_alarm_select_two;
  logic thermistor_mode_setting;
  logic [1:0] status;
  logic [1:0] irq_mask;
  lacls_word_t next_sel_one;
  lacls_word_t next_sel_two;
  logic next_therm;
  logic [1:0] next_status;
  logic [1:0] next_irq_mask;
  logic next_ack;
  logic [31:0] next_dat;
  logic bus_req;
  logic wr_go;
  logic minor_ev;
  logic trip_ev;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go = bus_req & wb_we_i;

  // byte-lane merge for 16-bit registers; any value fits 0000-FFFF
  function automatic lacls_word_t lane_merge(input lacls_word_t old, input logic [31:0] d, input logic [3:0] s);
    lane_merge = old;
    if (s[0]) lane_merge[7:0] = d[7:0];
    if (s[1]) lane_merge[15:8] = d[15:8];
  endfunction

  always_comb begin
    next_sel_one = minor_alarm_select_one;
    next_sel_two = minor_alarm_select_two;
    next_therm = thermistor_mode_setting;
    next_irq_mask = irq_mask;
    next_status = status;
    next_ack = bus_req;
    next_dat = 32'h00000000;
    if (wr_go) begin
      unique case (wb_adr_i)
        `LACLS_OFS_SEL_ONE: next_sel_one = lane_merge(minor_alarm_select_one, wb_dat_i, wb_sel_i);
        `LACLS_OFS_SEL_TWO: next_sel_two = lane_merge(minor_alarm_select_two, wb_dat_i, wb_sel_i);
        `LACLS_OFS_THERM: if (wb_sel_i[0]) next_therm = wb_dat_i[0];
        `LACLS_OFS_STATUS: if (wb_sel_i[0]) next_status = status & ~wb_dat_i[1:0];
        `LACLS_OFS_MASK: if (wb_sel_i[0]) next_irq_mask = wb_dat_i[1:0];
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    if (minor_ev) next_status[`LACLS_ST_MINOR] = 1'b1;
    if (trip_ev) next_status[`LACLS_ST_TRIP] = 1'b1;
    if (bus_req & ~wb_we_i) begin
      unique case (wb_adr_i)
        `LACLS_OFS_SEL_ONE: next_dat = {16'h0000, minor_alarm_select_one};
        `LACLS_OFS_SEL_TWO: next_dat = {16'h0000, minor_alarm_select_two};
        `LACLS_OFS_THERM: next_dat = {31'h0, thermistor_mode_setting};
        `LACLS_OFS_STATUS: next_dat = {30'h0, status};
        `LACLS_OFS_MASK: next_dat = {30'h0, irq_mask};
        `LACLS_OFS_DISP: next_dat = {28'h0, minor_ind_o, keypad_led_o, minor_alarm_output_o, trip_o};
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      minor_alarm_select_one <= `LACLS_SEL_RESET;
      minor_alarm_select_two <= `LACLS_SEL_RESET;
      thermistor_mode_setting <= 1'b0;
      status <= 2'h0;
      irq_mask <= 2'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      minor_alarm_select_one <= next_sel_one;
      minor_alarm_select_two <= next_sel_two;
      thermistor_mode_setting <= next_therm;
      status <= next_status;
      irq_mask <= next_irq_mask;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ==========================================================
  // classification
  lacls_word_t eff_one;
  lacls_word_t eff_two;
  lacls_word_t minor_two;
  lacls_word_t trip_two;
  logic any_minor;
  logic any_trip;
  logic therm_hit;
  logic prev_minor;
  logic prev_trip;
  logic blink;

  // unassigned positions ignore both fault and mask
  assign eff_one = f1_s2 & `LACLS_ONE_USED;
  assign eff_two = f2_s2 & `LACLS_TWO_USED;
  assign therm_hit = thermistor_mode_setting & eff_two[`LACLS_THERM_BIT];
  always_comb begin
    minor_two = eff_two & minor_alarm_select_two;
    trip_two = eff_two & ~minor_alarm_select_two;
    if (therm_hit) begin
      minor_two[`LACLS_THERM_BIT] = 1'b0;
      trip_two[`LACLS_THERM_BIT] = 1'b1;
    end
  end
  assign any_minor = (|(eff_one & minor_alarm_select_one)) | (|minor_two);
  assign any_trip = (|(eff_one & ~minor_alarm_select_one)) | (|trip_two);
  assign minor_ev = any_minor & ~prev_minor;
  assign trip_ev = any_trip & ~prev_trip;

  lacls_blink #(
    .HALF(BLINK_HALF)
  ) u_blink (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_o(blink)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_minor <= 1'b0;
      prev_trip <= 1'b0;
      trip_o <= 1'b0;
      minor_alarm_output_o <= 1'b0;
      minor_ind_o <= 1'b0;
      keypad_led_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      prev_minor <= any_minor;
      prev_trip <= any_trip;
      trip_o <= any_trip;
      minor_alarm_output_o <= any_minor;
      minor_ind_o <= any_minor;
      keypad_led_o <= any_minor & blink;
      irq_o <= |(next_status & irq_mask);
    end
  end

  // ==========================================================
  // hex display of both masks
  logic [7:0] chr [8];
  logic [31:0] both;
  assign both = {minor_alarm_select_one, minor_alarm_select_two};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dig
      lacls_hex_digit u_dig (
        .nib_i(both[gi*4 +: 4]),
        .chr_o(chr[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_one_d3_o <= 8'h30;
      disp_one_d2_o <= 8'h30;
      disp_one_d1_o <= 8'h30;
      disp_one_d0_o <= 8'h30;
      disp_two_d3_o <= 8'h30;
      disp_two_d2_o <= 8'h30;
      disp_two_d1_o <= 8'h30;
      disp_two_d0_o <= 8'h30;
    end else begin
      disp_one_d3_o <= chr[7];
      disp_one_d2_o <= chr[6];
      disp_one_d1_o <= chr[5];
      disp_one_d0_o <= chr[4];
      disp_two_d3_o <= chr[3];
      disp_two_d2_o <= chr[2];
      disp_two_d1_o <= chr[1];
      disp_two_d0_o <= chr[0];
    end
  end

  // ==========================================================
  // checks
  // classification
  thermistor_forced_trip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    therm_hit |=> trip_o)
    else $error("thermistor in mode one did not trip");
  thermistor_no_minor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    therm_hit && !(|(eff_one & minor_alarm_select_one))
    && !(|(eff_two & minor_alarm_select_two & ~(16'h0001 << `LACLS_THERM_BIT)))
    |=> !minor_alarm_output_o && !keypad_led_o)
    else $error("thermistor in mode one raised minor alarm");
  minor_output_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    any_minor |=> minor_alarm_output_o && minor_ind_o)
    else $error("minor alarm output not raised");
  masked_one_minor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(eff_one & minor_alarm_select_one)) |=> minor_alarm_output_o)
    else $error("masked fault not minor");
  masked_two_minor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|minor_two) |=> minor_alarm_output_o)
    else $error("masked fault of mask two not minor");
  unmasked_one_trip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(eff_one & ~minor_alarm_select_one)) |=> trip_o)
    else $error("unmasked fault did not trip");
  unmasked_two_trip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(eff_two & ~minor_alarm_select_two)) |=> trip_o)
    else $error("unmasked fault of mask two did not trip");
  led_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !any_minor |=> !keypad_led_o)
    else $error("led blinks with no minor alarm");
  led_blink_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    any_minor && blink |=> keypad_led_o)
    else $error("led dark in blink phase of minor alarm");
  minor_status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    minor_ev |=> status[`LACLS_ST_MINOR])
    else $error("minor alarm event not recorded");
  trip_status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trip_ev |=> status[`LACLS_ST_TRIP])
    else $error("trip event not recorded");
  unused_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((f1_s2 & `LACLS_ONE_USED) == 16'h0 && (f2_s2 & `LACLS_TWO_USED) == 16'h0) |=> !trip_o && !minor_alarm_output_o)
    else $error("unassigned bit had effect");
  // display
  disp_top_digit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (minor_alarm_select_one[15:12] == 4'hF) |=> (disp_one_d3_o == 8'h66))
    else $error("leftmost digit wrong");
  disp_two_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (minor_alarm_select_two[15:12] == 4'h3) |=> (disp_two_d3_o == 8'h33))
    else $error("leftmost digit of mask two wrong");
  disp_mid_digit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (minor_alarm_select_one[11:8] == 4'hC) |=> (disp_one_d2_o == 8'h63))
    else $error("letter digit wrong");
  disp_low_digit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (minor_alarm_select_two[3:0] == 4'h9) |=> (disp_two_d0_o == 8'h39))
    else $error("low digit wrong");
  // register bus
  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && wb_adr_i == `LACLS_OFS_SEL_ONE && wb_sel_i == 4'hF)
    |=> minor_alarm_select_one == $past(wb_dat_i[15:0]))
    else $error("mask one write lost");
  mask_two_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && wb_adr_i == `LACLS_OFS_SEL_TWO && wb_sel_i == 4'hF)
    |=> minor_alarm_select_two == $past(wb_dat_i[15:0]))
    else $error("mask two write lost");
endmodule

// [lacls_fault_src.sv]
// model of the drive fault detectors feeding the classifier
`timescale 1ns/10ps
module lacls_fault_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] one_i,
  input wire logic [15:0] two_i,
  output logic [15:0] fault_one_o,
  output logic [15:0] fault_two_o
);
  // detectors hold a fault level until told otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_one_o <= 16'h0000;
      fault_two_o <= 16'h0000;
    end else if (load_i) begin
      fault_one_o <= one_i;
      fault_two_o <= two_i;
    end
  end
endmodule

// [light_alarm_classifier_test.sv]
// self-checking bench for the light alarm classifier
`timescale 1ns/10ps
`include "lacls_regs.svh"
module light_alarm_classifier_test;
  import lacls_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic ld = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hF;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, trip, minor, ind, led, irq;
  logic [15:0] fs_one = 16'h0;
  logic [15:0] fs_two = 16'h0;
  logic [15:0] f_one, f_two;
  lacls_char_t d[8];
  int err_total = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  always #5 clk_i = ~clk_i;
  lacls_top #(.BLINK_HALF(26'h4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fault_one_i(f_one), .fault_two_i(f_two), .trip_o(trip), .minor_alarm_output_o(minor),
    .minor_ind_o(ind), .keypad_led_o(led), .disp_one_d3_o(d[3]), .disp_one_d2_o(d[2]),
    .disp_one_d1_o(d[1]), .disp_one_d0_o(d[0]), .disp_two_d3_o(d[7]), .disp_two_d2_o(d[6]),
    .disp_two_d1_o(d[5]), .disp_two_d0_o(d[4]), .irq_o(irq));
  lacls_fault_src u_src (.clk_i(clk_i), .rst_i(rst_i), .load_i(ld), .one_i(fs_one), .two_i(fs_two),
    .fault_one_o(f_one), .fault_two_o(f_two));
  // ==========================================
  // shared tasks
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= lanes;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
  endtask
  // fault levels land three edges after the detector changes
  task automatic flt(input logic [15:0] one, input logic [15:0] two);
    @(posedge clk_i);
    fs_one <= one;
    fs_two <= two;
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic outs(input logic t, input logic m);
    chk({trip, minor, ind}, {t, m, m});
  endtask
  // expected characters from a plain table, not from arithmetic
  function automatic lacls_char_t hx(input lacls_nib_t n);
    string digits;
    digits = "0123456789abcdef";
    return digits[n];
  endfunction
  // ==========================================
  // scenarios
  task automatic t_reset();
    wb(1'b0, `LACLS_OFS_SEL_ONE, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `LACLS_OFS_SEL_TWO, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 8; k++) chk(d[k], 8'h30);
    outs(1'b0, 1'b0);
  endtask
  task automatic t_display();
    logic [15:0] m1[3] = '{16'h3421, 16'hE465, 16'hFC77};
    logic [15:0] m2[3] = '{16'h2AB8, 16'h2D9C, 16'h3FFC};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `LACLS_OFS_SEL_ONE, {16'h0, m1[i]});
      wb(1'b1, `LACLS_OFS_SEL_TWO, {16'h0, m2[i]});
      wb(1'b0, `LACLS_OFS_SEL_ONE, 32'h0);
      chk(rd, {16'h0, m1[i]});
      for (int k = 0; k < 4; k++) begin
        chk(d[k], hx(m1[i][4 * k +: 4]));
        chk(d[k + 4], hx(m2[i][4 * k +: 4]));
      end
    end
  endtask
  task automatic t_classify();
    logic hi, lo;
    wb(1'b1, `LACLS_OFS_SEL_ONE, 32'h00000221);
    wb(1'b1, `LACLS_OFS_SEL_TWO, 32'h00000800);
    wb(1'b1, `LACLS_OFS_THERM, 32'h0);
    flt(16'h0001, 16'h0);
    outs(1'b0, 1'b1);
    hi = 1'b0;
    lo = 1'b0;
    repeat (12) begin
      @(posedge clk_i);
      hi |= (led === 1'b1);
      lo |= (led === 1'b0);
    end
    chk({hi, lo}, 2'b11);
    flt(16'h0002, 16'h0);
    outs(1'b1, 1'b0);
    flt(16'h0200, 16'h0);
    outs(1'b0, 1'b0);
    // bit 5 is selected in mask one, so motor overload is a minor alarm
    flt(16'h0020, 16'h0);
    outs(1'b0, 1'b1);
    flt(16'h0000, 16'h0800);
    outs(1'b0, 1'b1);
    wb(1'b1, `LACLS_OFS_THERM, 32'h1);
    flt(16'h0000, 16'h0800);
    outs(1'b1, 1'b0);
    chk(led, 1'b0);
    flt(16'h0000, 16'h0004);
    outs(1'b1, 1'b0);
  endtask
  task automatic t_irq();
    wb(1'b1, `LACLS_OFS_SEL_ONE, 32'h00000001);
    flt(16'h0000, 16'h0000);
    wb(1'b1, `LACLS_OFS_STATUS, 32'h3);
    wb(1'b1, `LACLS_OFS_MASK, 32'h1);
    flt(16'h0001, 16'h0000);
    chk(irq, 1'b1);
    wb(1'b0, `LACLS_OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, `LACLS_OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    flt(16'h0002, 16'h0000);
    chk(irq, 1'b0);
    wb(1'b0, `LACLS_OFS_STATUS, 32'h0);
    chk(rd, 32'h2);
    // readback order: minor indication, led, minor output, trip
    wb(1'b0, `LACLS_OFS_DISP, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, `LACLS_OFS_THERM, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, `LACLS_OFS_MASK, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, 4'h6, 32'h0000FFFF);
    wb(1'b0, 4'h6, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `LACLS_OFS_SEL_ONE, 32'h0);
    chk(rd, 32'h1);
    // only the upper byte lane of mask one is written
    lanes = 4'h2;
    wb(1'b1, `LACLS_OFS_SEL_ONE, 32'h0000ABCD);
    lanes = 4'hF;
    wb(1'b0, `LACLS_OFS_SEL_ONE, 32'h0);
    chk(rd, 32'h0000AB01);
  endtask
  // ==========================================
  // run and watchdog
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_display();
    t_classify();
    t_irq();
    conclude();
  end
endmodule
